// ==== dxw_pkg.sv ====
package dxw_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] DXW_OFF_XBASE = 8'ha8;
  localparam logic [7:0] DXW_OFF_SETUP = 8'hac;
  localparam logic [7:0] DXW_OFF_CAPHDR = 8'hb0;
  // ==========================================================
  // field positions
  localparam int DXW_XBASE_LSB = 6;
  localparam int DXW_SETUP_EN_BIT = 31;
  localparam int DXW_SETUP_PF_BIT = 3;
  localparam int DXW_SETUP_AT_LSB = 1;
  // ==========================================================
  // reset and constant values
  localparam logic [31:0] DXW_XBASE_RST = 32'h0000_0000;
  localparam logic [31:0] DXW_SETUP_RST = 32'h0000_0000;
  localparam logic [7:0] DXW_CAP_ID = 8'h10;
  localparam logic [7:0] DXW_CAP_NEXT = 8'hd8;
  localparam logic [3:0] DXW_CAP_VER = 4'h1;
  localparam logic [3:0] DXW_PORT_FWD = 4'h7;
  localparam logic [3:0] DXW_PORT_REV = 4'h8;
  localparam logic [1:0] DXW_AT_32 = 2'h0;
  localparam logic [1:0] DXW_AT_64 = 2'h1;
  // writable base bits come from size mask bits 30:6
  localparam logic [31:0] DXW_MASK_FIELD = 32'h7fff_ffc0;
  localparam logic [31:0] DXW_SETUP_WMASK = 32'hffff_ffce;
endpackage

// ==== dxw_xlate.sv ====
`timescale 1ns/100ps
`default_nettype none
// address substitution for window one, registered output
module dxw_xlate
  import dxw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_base,
  input wire logic [31:0] i_setup,
  output logic o_hit,
  output logic [31:0] o_addr
);
  logic hit_d;
  logic hit_q;
  logic [31:0] addr_d;
  logic [31:0] addr_q;
  logic [31:0] mask;

  // ==========================================================
  // substitution
  always_comb begin
    mask = i_setup & DXW_MASK_FIELD;
    hit_d = i_req & i_setup[DXW_SETUP_EN_BIT];
    addr_d = (i_base & mask) | (i_addr & ~mask);
    if (!hit_d) begin
      addr_d = i_addr;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hit_q <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else begin
      hit_q <= hit_d;
      addr_q <= addr_d;
    end
  end

  assign o_hit = hit_q;
  assign o_addr = addr_q;
endmodule
`default_nettype wire

// ==== dxw_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - translated base bits 30:6, reset zero
// - translation uses only size-mask-enabled base bits
// - setup bit 0 reads zero: memory
// - address width field bits 2:1
// - mask bit set makes base bit writable
// - setup bit 31 enables window decode
// - capability id reads 10h
// - next pointer reads D8h
// - port type 0111 forward, 1000 reverse
// - slot implemented bit follows reverse mode
module dxw_regs
  import dxw_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_reverse_mode,
  input wire logic i_setup_load_writable,
  input wire logic [31:0] i_setup_load_data,
  input wire logic i_req,
  input wire logic [31:0] i_req_addr,
  output logic o_win_enabled,
  output logic o_xlate_hit,
  output logic [31:0] o_xlate_addr
);
  // ==========================================================
  // elaboration check
  if (ADDR_W < 8) begin : g_chk
    $error("dxw_regs: ADDR_W must be at least 8");
  end

  logic [31:0] base_q;
  logic [31:0] base_d;
  logic [31:0] setup_q;
  logic [31:0] setup_d;
  logic rev_q;
  logic rev_d;
  logic ready_q;
  logic ready_d;
  logic err_q;
  logic err_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] lane_mask;
  logic [31:0] wmask;
  logic access;
  logic hit_base;
  logic hit_setup;
  logic hit_cap;

  // byte strobes expand into a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // capability header word, mode dependent
  function automatic logic [31:0] cap_word(input logic rev);
    cap_word = 32'h0000_0000;
    cap_word[7:0] = DXW_CAP_ID;
    cap_word[15:8] = DXW_CAP_NEXT;
    cap_word[19:16] = DXW_CAP_VER;
    cap_word[23:20] = rev ? DXW_PORT_REV : DXW_PORT_FWD;
    cap_word[24] = rev;
  endfunction

  // ==========================================================
  // apb decode: one wait state, pready rises a cycle after access
  // registered answer keeps every output straight from a flop
  always_comb begin
    access = i_psel & i_penable & ~ready_q;
    hit_base = i_paddr == ADDR_W'(DXW_OFF_XBASE);
    hit_setup = i_paddr == ADDR_W'(DXW_OFF_SETUP);
    hit_cap = i_paddr == ADDR_W'(DXW_OFF_CAPHDR);
    lane_mask = strb_mask(i_pstrb);
    // base bits writable only where size mask allows
    wmask = lane_mask & setup_q & DXW_MASK_FIELD;
    ready_d = access;
    err_d = access & ~(hit_base | hit_setup | hit_cap);
    rdata_d = 32'h0000_0000;
    if (access && !i_pwrite) begin
      if (hit_base) begin
        rdata_d = base_q;
      end else if (hit_setup) begin
        rdata_d = setup_q;
      end else if (hit_cap) begin
        rdata_d = cap_word(rev_q);
      end
    end
  end

  // ==========================================================
  // register state
  always_comb begin
    base_d = base_q;
    setup_d = setup_q;
    rev_d = i_reverse_mode;
    // host writes to setup and header are dropped
    if (access && i_pwrite && hit_base) begin
      base_d = (base_q & ~wmask) | (i_pwdata & wmask);
    end
    // side load path only; bit 0 and 5:4 forced zero
    if (i_setup_load_writable) begin
      setup_d = i_setup_load_data & DXW_SETUP_WMASK;
    end
    // 11:6 left as loaded; loader is trusted here
    setup_d[0] = 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      base_q <= DXW_XBASE_RST;
      setup_q <= DXW_SETUP_RST;
      rev_q <= 1'b0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      base_q <= base_d;
      setup_q <= setup_d;
      rev_q <= rev_d;
      ready_q <= ready_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // translation datapath
  dxw_xlate u_xlate (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_req(i_req),
    .i_addr(i_req_addr),
    .i_base(base_q),
    .i_setup(setup_q),
    .o_hit(o_xlate_hit),
    .o_addr(o_xlate_addr)
  );

  assign o_pready = ready_q;
  assign o_pslverr = err_q;
  assign o_prdata = rdata_q;
  assign o_win_enabled = setup_q[DXW_SETUP_EN_BIT];
endmodule
`default_nettype wire

// ==== dxw_regs_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module dxw_regs_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_req,
  input wire logic [31:0] i_req_addr,
  input wire logic i_setup_load_writable,
  input wire logic [31:0] i_setup_load_data,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_win_enabled,
  input wire logic o_xlate_hit,
  input wire logic [31:0] o_xlate_addr
);
  // ==========================================================
  // port relations; reset masks every check
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  rdy_after_access_a: assert property (
    i_psel && i_penable && !o_pready |=> o_pready) else $error("no ready");
  rdata_idle_a: assert property (
    !o_pready |-> o_prdata == 32'h0) else $error("stale read data");
  err_with_rdy_a: assert property (
    o_pslverr |-> o_pready) else $error("error without ready");
  en_from_load_a: assert property (
    i_setup_load_writable |=> o_win_enabled == $past(i_setup_load_data[31]))
    else $error("enable not loaded");
  en_holds_a: assert property (
    !i_setup_load_writable |=> $stable(o_win_enabled))
    else $error("enable moved");
  hit_when_en_a: assert property (
    i_req && o_win_enabled |=> o_xlate_hit) else $error("missed hit");
  miss_when_off_a: assert property (
    i_req && !o_win_enabled |=>
      !o_xlate_hit && o_xlate_addr == $past(i_req_addr))
    else $error("disabled window translated");
  fixed_bits_kept_a: assert property (
    i_req |=>
      ((o_xlate_addr ^ $past(i_req_addr)) & 32'h8000_003f) == 32'h0)
    else $error("unmasked bits changed");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dxw_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, i_reverse_mode = 1'b0, i_req = 1'b0;
  logic i_setup_load_writable = 1'b0, e, o_pready, o_pslverr;
  logic o_win_enabled, o_xlate_hit;
  logic [7:0] i_paddr = 8'h00;
  logic [3:0] i_pstrb = 4'hf;
  logic [31:0] i_pwdata = 32'h0, i_setup_load_data = 32'h0;
  logic [31:0] i_req_addr = 32'h0, o_prdata, o_xlate_addr, r;
  int fails = 0, compares = 0;
  dxw_regs u_dut (.i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr,
    .i_reverse_mode, .i_setup_load_writable, .i_setup_load_data, .i_req,
    .i_req_addr, .o_win_enabled, .o_xlate_hit, .o_xlate_addr);
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // one apb transfer; waits on pready, never a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("unexpected at %0t: no pready", $time);
    end
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic load(input logic [31:0] d);
    i_setup_load_writable <= 1'b1;
    i_setup_load_data <= d;
    @(posedge i_clk);
    i_setup_load_writable <= 1'b0;
    @(posedge i_clk);
  endtask
  // sample after the edge lands, then realign to the clock
  task automatic xl(input logic [31:0] a, input logic h,
                    input logic [31:0] x);
    i_req <= 1'b1;
    i_req_addr <= a;
    @(posedge i_clk);
    i_req <= 1'b0;
    #1;
    chk({31'h0, o_xlate_hit}, {31'h0, h});
    chk(o_xlate_addr, x);
    @(posedge i_clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    apb(1'b0, DXW_OFF_XBASE, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, DXW_OFF_SETUP, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, DXW_OFF_CAPHDR, 32'h0);
    chk(r, 32'h0071_d810);
    $display("reset test done");
  endtask
  task automatic t_window;
    apb(1'b1, DXW_OFF_XBASE, 32'hffff_ffff);
    apb(1'b0, DXW_OFF_XBASE, 32'h0);
    chk(r, 32'h0);
    load(32'h8000_f00b);
    chk({31'h0, o_win_enabled}, 32'h1);
    apb(1'b1, DXW_OFF_SETUP, 32'h0);
    apb(1'b0, DXW_OFF_SETUP, 32'h0);
    chk(r, 32'h8000_f00a);
    apb(1'b1, DXW_OFF_XBASE, 32'hffff_ffff);
    apb(1'b0, DXW_OFF_XBASE, 32'h0);
    chk(r, 32'h0000_f000);
    // lane 0 holds no writable bit, so the base must not move
    i_pstrb <= 4'h1;
    apb(1'b1, DXW_OFF_XBASE, 32'h0);
    i_pstrb <= 4'hf;
    apb(1'b0, DXW_OFF_XBASE, 32'h0);
    chk(r, 32'h0000_f000);
    xl(32'h1234_5678, 1'b1, 32'h1234_f678);
    load(32'h0000_f000);
    chk({31'h0, o_win_enabled}, 32'h0);
    xl(32'h1234_5678, 1'b0, 32'h1234_5678);
    $display("window test done");
  endtask
  task automatic t_rev;
    i_reverse_mode <= 1'b1;
    repeat (2) @(posedge i_clk);
    apb(1'b0, DXW_OFF_CAPHDR, 32'h0);
    chk(r, 32'h0181_d810);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("reverse test done");
  endtask
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, sequence, watchdog
  initial forever #5 i_clk = ~i_clk;
  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    t_reset;
    t_window;
    t_rev;
    close_out;
  end
  initial begin
    repeat (2000) @(posedge i_clk);
    fails++;
    close_out;
  end
endmodule
bind dxw_regs dxw_regs_checker u_chk (.i_clk, .i_resetn, .i_psel,
  .i_penable, .i_req, .i_req_addr, .i_setup_load_writable,
  .i_setup_load_data, .o_pready, .o_prdata, .o_pslverr, .o_win_enabled,
  .o_xlate_hit, .o_xlate_addr);
`default_nettype wire
